// ==== logic/tcp_pkg.sv ====
// Shared constants and types of the 16-bit timer, counter and PWM unit.
// Assumes an AHB-Lite register port with 32-bit data, one word per register.
package tcp_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int TCP_CNT_W = 16;
  localparam int TCP_DB_W = 8;
  localparam int TCP_ADDR_W = 8;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PERIOD = 8'h04;
  localparam logic [7:0] OFS_COMPARE = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0C;
  localparam logic [7:0] OFS_CAPTURE = 8'h10;
  localparam logic [7:0] OFS_DEADBAND = 8'h14;
  localparam logic [7:0] OFS_DIVIDER = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_CLEAR = 8'h20;
  localparam logic [7:0] OFS_IRQ_EN = 8'h24;

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_CMP_LSB = 3;
  localparam int CTRL_TCCOMP_BIT = 6;
  localparam int CTRL_CLK_LSB = 8;
  localparam logic [9:0] CTRL_MASK = 10'h37F;

  // Status, clear and enable share this layout
  localparam int ST_TC_BIT = 0;
  localparam int ST_CMP_BIT = 1;
  localparam int ST_CAP_BIT = 2;
  localparam int ST_W = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [9:0] CTRL_RST = 10'h000;
  localparam logic [15:0] PERIOD_RST = 16'hFFFF;
  localparam logic [15:0] COMPARE_RST = 16'h8000;
  localparam logic [7:0] DEADBAND_RST = 8'h00;
  localparam logic [15:0] DIVIDER_RST = 16'h0000;
  localparam logic [2:0] IRQ_EN_RST = 3'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RUN_FREE,
    RUN_ONESHOT,
    RUN_GATED
  } tcp_run_t;

  typedef enum logic [2:0] {
    CMP_LESS,
    CMP_LESS_OR_EQUAL,
    CMP_EQUAL,
    CMP_GREATER_OR_EQUAL,
    CMP_GREATER
  } tcp_cmp_t;

  typedef enum logic [1:0] {
    CLK_SYS,
    CLK_DIV,
    CLK_EXT_LEVEL,
    CLK_EXT_EDGE
  } tcp_clk_t;

  typedef enum logic [1:0] {
    TS_IDLE,
    TS_RUN,
    TS_DONE
  } tcp_state_t;

  // Signals arriving from the routing fabric
  typedef struct packed {
    logic enable;
    logic restart;
    logic capture;
    logic kill;
    logic extClk;
  } tcp_fab_in_t;

  // Signals leaving toward the routing fabric
  typedef struct packed {
    logic cmp;
    logic tc;
  } tcp_fab_out_t;

endpackage

// ==== logic/tcp_deadband.sv ====
// Deadband generator: splits one compare level into two complementary
// drives with both off for a programmable number of counting ticks.
// Assumes tickEn is a one-cycle enable from the counting clock select.
`timescale 1ns/100ps
`default_nettype none
module tcp_deadband
  import tcp_pkg::*;
#(
  parameter int DBW = TCP_DB_W
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic tickEn,
  input wire logic rawLevel,
  input wire logic [DBW-1:0] deadTicks,
  output logic driveHigh,
  output logic driveLow
);

  logic level;
  logic [DBW-1:0] remain;

  // ----------------------------------------------------------------
  // Transition tracking
  // ----------------------------------------------------------------
  // Both sides go off on a change, the new side waits out the gap
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      level <= 1'b0;
      remain <= '0;
      driveHigh <= 1'b0;
      driveLow <= 1'b0;
    end else if (tickEn) begin
      if (rawLevel != level) begin
        level <= rawLevel;
        remain <= deadTicks;
        driveHigh <= 1'b0;
        driveLow <= 1'b0;
      end else if (remain != '0) begin
        remain <= remain - 1'b1;
      end else begin
        driveHigh <= level;
        driveLow <= !level;
      end
    end
  end

endmodule
`default_nettype wire

// ==== logic/tcp_timer.sv ====
// 16-bit down-counting timer, counter and PWM with AHB-Lite registers.
// Assumes fabric inputs already synchronous to clk; one bus master.
//
// What this block does
// - The counter is 16 bits wide and only ever counts down.
// - The period is loaded on start, on restart input and at zero.
// - Compare output uses one chosen relation: <, <=, ==, >= or >.
// - An interrupt rises on any enabled tc, compare or capture event.
// - Runs free, as a single pass, or gated by the enable input.
// - A single pass stops at the end of the period with no reload.
// - Gated runs count only on ticks with enable high.
// - A restart input restarts; a capture input stores the count.
// - While kill is high the PWM outputs are forced inactive.
// - Outputs are compare and tc, tc optionally the complement.
// - Complementary PWM outputs are split by a deadband gap.
// - The counting clock is selectable; pins go via the fabric.
`timescale 1ns/100ps
`default_nettype none
module tcp_timer
  import tcp_pkg::*;
#(
  parameter int W = TCP_CNT_W,
  parameter int DBW = TCP_DB_W
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire tcp_fab_in_t fabIn,
  output tcp_fab_out_t fabOut,
  output logic irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [9:0] ctrl;
  logic [W-1:0] period;
  logic [W-1:0] compare;
  logic [W-1:0] count;
  logic [W-1:0] capture;
  logic [DBW-1:0] deadband;
  logic [W-1:0] divider;
  logic [W-1:0] divCnt;
  logic [ST_W-1:0] status;
  logic [ST_W-1:0] irqEn;
  logic [ST_W-1:0] next_status;
  logic [ST_W-1:0] events;
  logic [ST_W-1:0] clrBits;
  logic [TCP_ADDR_W-1:0] wrAddr;
  logic wrPend;
  logic addrPhase;
  logic [31:0] rdMux;
  tcp_state_t state;
  tcp_run_t runMode;
  tcp_cmp_t cmpMode;
  tcp_clk_t clkSel;
  logic runPrev;
  logic startPulse;
  logic divTick;
  logic extPrev;
  logic capPrev;
  logic tick;
  logic countEn;
  logic tcHit;
  logic cmpTrue;
  logic cmpPrev;
  logic pwmHigh;
  logic pwmLow;
  logic sizeUnused;

  // ----------------------------------------------------------------
  // Compare relation
  // ----------------------------------------------------------------
  function automatic logic cmpEval(input logic [W-1:0] a,
                                   input logic [W-1:0] b,
                                   input tcp_cmp_t m);
    logic r;
    r = 1'b0;
    unique case (m)
      CMP_LESS: r = a < b;
      CMP_LESS_OR_EQUAL: r = a <= b;
      CMP_EQUAL: r = a == b;
      CMP_GREATER_OR_EQUAL: r = a >= b;
      CMP_GREATER: r = a > b;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  // Code 3 of the run field falls back to free running
  assign runMode = tcp_run_t'(ctrl[CTRL_MODE_LSB +: 2]);
  assign cmpMode = tcp_cmp_t'(ctrl[CTRL_CMP_LSB +: 3]);
  assign clkSel = tcp_clk_t'(ctrl[CTRL_CLK_LSB +: 2]);
  // Every access is a word; hsize is read only to be folded away
  assign sizeUnused = ^hsize;

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  // Hready low from another slave holds the address phase off
  assign addrPhase = hsel && htrans[1] && hready;

  // Zero wait states; read data is sampled during the address phase
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPend <= 1'b0;
      wrAddr <= '0;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wrPend <= addrPhase && hwrite;
      wrAddr <= haddr[TCP_ADDR_W-1:0];
      hrdata <= (addrPhase && !hwrite) ? rdMux : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Read decode, unmapped and write-only words read zero
  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (haddr[TCP_ADDR_W-1:0])
      OFS_CTRL: rdMux[9:0] = ctrl;
      OFS_PERIOD: rdMux[W-1:0] = period;
      OFS_COMPARE: rdMux[W-1:0] = compare;
      OFS_COUNT: rdMux[W-1:0] = count;
      OFS_CAPTURE: rdMux[W-1:0] = capture;
      OFS_DEADBAND: rdMux[DBW-1:0] = deadband;
      OFS_DIVIDER: rdMux[W-1:0] = divider;
      OFS_STATUS: rdMux[ST_W-1:0] = status;
      OFS_IRQ_EN: rdMux[ST_W-1:0] = irqEn;
      default: rdMux = 32'h0000_0000;
    endcase
  end

  // Register writes land at the end of the data phase
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= CTRL_RST;
      period <= PERIOD_RST;
      compare <= COMPARE_RST;
      deadband <= DEADBAND_RST;
      divider <= DIVIDER_RST;
      irqEn <= IRQ_EN_RST;
    end else if (wrPend) begin
      unique case (wrAddr)
        OFS_CTRL: ctrl <= hwdata[9:0] & CTRL_MASK;
        OFS_PERIOD: period <= hwdata[W-1:0];
        OFS_COMPARE: compare <= hwdata[W-1:0];
        OFS_DEADBAND: deadband <= hwdata[DBW-1:0];
        OFS_DIVIDER: divider <= hwdata[W-1:0];
        OFS_IRQ_EN: irqEn <= hwdata[ST_W-1:0];
        default: ;
      endcase
    end
  end

  // Clear register is write-only, one pulse per write
  assign clrBits = (wrPend && wrAddr == OFS_CLEAR) ?
                   hwdata[ST_W-1:0] : '0;

  // ----------------------------------------------------------------
  // Counting clock select
  // ----------------------------------------------------------------
  // Divider period is divider+1 system cycles
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      divCnt <= '0;
    end else if (divCnt == '0) begin
      divCnt <= divider;
    end else begin
      divCnt <= divCnt - 1'b1;
    end
  end
  // A new divider value only takes effect once the current count expires
  assign divTick = divCnt == '0;

  // Edge history of fabric inputs, the run bit and the compare result
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      extPrev <= 1'b0;
      capPrev <= 1'b0;
      runPrev <= 1'b0;
      cmpPrev <= 1'b0;
    end else begin
      extPrev <= fabIn.extClk;
      capPrev <= fabIn.capture;
      runPrev <= ctrl[CTRL_RUN_BIT];
      cmpPrev <= cmpTrue;
    end
  end

  // One enable pulse per counting clock, but every cycle extClk is high in level mode; never a derived clock
  always_comb begin
    unique case (clkSel)
      CLK_SYS: tick = 1'b1;
      CLK_DIV: tick = divTick;
      CLK_EXT_LEVEL: tick = fabIn.extClk;
      CLK_EXT_EDGE: tick = fabIn.extClk && !extPrev;
    endcase
  end

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  assign startPulse = ctrl[CTRL_RUN_BIT] && !runPrev;
  assign countEn = tick &&
                   (runMode != RUN_GATED || fabIn.enable);
  // A load in the same cycle takes priority over the zero event
  assign tcHit = state == TS_RUN && countEn && count == '0 &&
                 !startPulse && !fabIn.restart;

  // Clearing the run bit always parks the counter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= TS_IDLE;
    end else begin
      unique case (state)
        TS_IDLE: begin
          if (startPulse) begin
            state <= TS_RUN;
          end
        end
        TS_RUN: begin
          if (!ctrl[CTRL_RUN_BIT]) begin
            state <= TS_IDLE;
          end else if (tcHit && runMode == RUN_ONESHOT) begin
            state <= TS_DONE;
          end
        end
        TS_DONE: begin
          if (!ctrl[CTRL_RUN_BIT]) begin
            state <= TS_IDLE;
          end else if (fabIn.restart) begin
            state <= TS_RUN;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Down counter
  // ----------------------------------------------------------------
  // Loads beat counting; a single pass parks at zero until restarted
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= PERIOD_RST;
    end else if (startPulse || fabIn.restart) begin
      count <= period;
    end else if (state == TS_RUN && countEn) begin
      if (count == '0) begin
        if (runMode != RUN_ONESHOT) begin
          count <= period;
        end
      end else begin
        count <= count - 1'b1;
      end
    end
  end

  // Capture on the rising edge of the capture input
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      capture <= '0;
    end else if (fabIn.capture && !capPrev) begin
      capture <= count;
    end
  end

  // ----------------------------------------------------------------
  // Compare and PWM outputs
  // ----------------------------------------------------------------
  // Unsigned relation, evaluated every clock, not only on ticks
  assign cmpTrue = cmpEval(count, compare, cmpMode);

  // Trade-off: a deadband of zero still costs one tick with both off
  tcp_deadband #(
    .DBW(DBW)
  ) uDeadband (
    .clk(clk),
    .rst_b(rst_b),
    .tickEn(tick),
    .rawLevel(cmpTrue),
    .deadTicks(deadband),
    .driveHigh(pwmHigh),
    .driveLow(pwmLow)
  );

  // Kill acts on the PWM drives only; a plain tc pulse is not masked
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fabOut <= '0;
    end else begin
      fabOut.cmp <= pwmHigh && !fabIn.kill;
      if (ctrl[CTRL_TCCOMP_BIT]) begin
        fabOut.tc <= pwmLow && !fabIn.kill;
      end else begin
        fabOut.tc <= tcHit;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  always_comb begin
    events = '0;
    events[ST_TC_BIT] = tcHit;
    events[ST_CMP_BIT] = cmpTrue && !cmpPrev;
    events[ST_CAP_BIT] = fabIn.capture && !capPrev;
    // A new event beats a clear in the same cycle
    next_status = (status & ~clrBits) | events;
  end

  // Irq follows next_status, so it rises on the same edge as the flag
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status <= '0;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      irq <= |(next_status & irqEn) || (sizeUnused && 1'b0);
    end
  end

endmodule
`default_nettype wire

// ==== dv/tcp_timer_asserts.sv ====
// Port-level checker for the timer, bound into tcp_timer.
// Assumes one AHB-Lite master and fabric inputs synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module tcp_timer_asserts
  import tcp_pkg::*;
#(
  parameter int W = TCP_CNT_W,
  parameter int DBW = TCP_DB_W
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire tcp_fab_in_t fabIn,
  input wire tcp_fab_out_t fabOut,
  input wire logic irq
);
  // ----------------------------------------------------------------
  // Bus snoop
  // ----------------------------------------------------------------
  logic wrPend;
  logic rdPend;
  logic [7:0] wrAddr;
  logic [9:0] ctrl;
  logic [2:0] irqEn;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Track data phases so outputs can be tied to the access causing them
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPend <= 1'b0;
      rdPend <= 1'b0;
      wrAddr <= 8'h00;
    end else begin
      wrPend <= hsel && htrans[1] && hready && hwrite;
      rdPend <= hsel && htrans[1] && hready && !hwrite;
      wrAddr <= haddr[7:0];
    end
  end

  // Mirror of control and enable, needed to know which output mode holds
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= CTRL_RST;
      irqEn <= IRQ_EN_RST;
    end else if (wrPend) begin
      if (wrAddr == OFS_CTRL) ctrl <= hwdata[9:0] & CTRL_MASK;
      if (wrAddr == OFS_IRQ_EN) irqEn <= hwdata[2:0];
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  sequence sKill;
    fabIn.kill ##1 fabIn.kill;
  endsequence
  sequence sPulse;
    !ctrl[CTRL_TCCOMP_BIT] && fabOut.tc;
  endsequence

  AST_HREADY: assert property (hreadyout)
    else $error("hreadyout low");
  AST_HRESP: assert property (!hresp)
    else $error("hresp not OKAY");
  AST_RDATA_IDLE: assert property (!rdPend |-> hrdata == 32'h0)
    else $error("hrdata outside read data phase");
  AST_KILL_CMP: assert property (sKill |-> !fabOut.cmp)
    else $error("cmp high under kill");
  AST_KILL_COMP: assert property (
      sKill |-> !ctrl[CTRL_TCCOMP_BIT] || !fabOut.tc)
    else $error("complement high under kill");
  AST_DEADBAND: assert property (
      ctrl[CTRL_TCCOMP_BIT] |-> !(fabOut.cmp && fabOut.tc))
    else $error("both drives high");
  AST_TC_PULSE: assert property (sPulse |=> !fabOut.tc)
    else $error("tc longer than one cycle");
  AST_IRQ_TC: assert property (
      sPulse ##0 irqEn[0] |-> ##[0:2] irq)
    else $error("tc did not raise irq");
  AST_IRQ_MASK: assert property (
      (irqEn == 3'h0) && ($past(irqEn) == 3'h0) && ($past(irqEn, 2) == 3'h0)
      |-> !irq)
    else $error("irq while masked");
endmodule

bind tcp_timer tcp_timer_asserts #(.W(W), .DBW(DBW)) u_chk (.clk(clk),
  .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fabIn(fabIn),
  .fabOut(fabOut), .irq(irq));
`default_nettype wire

// ==== dv/tcp_fabric_model.sv ====
// Model of the routing fabric feeding the timer's fabric inputs.
// Assumes commands from the bench arrive just after a clock edge.
`timescale 1ns/100ps
`default_nettype none
module tcp_fabric_model
  import tcp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire tcp_fab_in_t cmd,
  output tcp_fab_in_t fabIn
);
  logic [1:0] div;

  // One sync stage like the fabric; external clock idles low when off
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fabIn <= '0;
      div <= 2'h0;
    end else begin
      fabIn[4:1] <= cmd[4:1];
      div <= (cmd.extClk && div != 2'h2) ? div + 2'h1 : 2'h0;
      if (!cmd.extClk) fabIn.extClk <= 1'b0;
      else if (div == 2'h2) fabIn.extClk <= !fabIn.extClk;
    end
  end
endmodule
`default_nettype wire

// ==== dv/tcp_timer_test.sv ====
// Self-checking bench for tcp_timer over AHB-Lite and the fabric model.
// Assumes zero-wait slave; hready is tied back to hreadyout.
`timescale 1ns/100ps
`default_nettype none
module tcp_timer_test;
  import tcp_pkg::*;
  logic clk, rst_b, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  tcp_fab_in_t cmd, fabIn;
  tcp_fab_out_t fabOut;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  logic [7:0] ra [10] = '{OFS_CTRL, OFS_PERIOD, OFS_COMPARE, OFS_COUNT,
    OFS_CAPTURE, OFS_DEADBAND, OFS_DIVIDER, OFS_STATUS, OFS_IRQ_EN, 8'h40};
  logic [31:0] re [10] = '{32'h0, 32'hFFFF, 32'h8000, 32'hFFFF, 32'h0,
    32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

  tcp_timer u_dut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .fabIn(fabIn), .fabOut(fabOut), .irq(irq));
  tcp_fabric_model u_fab (.clk(clk), .rst_b(rst_b), .cmd(cmd),
    .fabIn(fabIn));

  // ----------------------------------------------------------------
  // Clock, timeout and verdict
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic complete_run();
    if (miscompares == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Generous ceiling; a normal run takes under two thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      miscompares = miscompares + 1;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      $display("[ERR] %0t saw %h want %h", $time, seen, exp);
      miscompares = miscompares + 1;
    end
  endtask

  // Holds each phase until hready is seen high; no wait count assumed
  task automatic ahb(input logic [7:0] a, input logic w,
      input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(a, 1'b1, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    ahb(a, 1'b0, 32'h0, q);
  endtask

  // Restart from stopped so the run bit sees a rising edge
  task automatic run(input logic [31:0] c);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_CTRL, c);
  endtask

  task automatic waitTc(input int lim, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (fabOut.tc !== 1'b1 && n < lim);
  endtask

  function automatic logic rel(int m, logic [15:0] a, logic [15:0] b);
    case (m)
      0: rel = a < b;
      1: rel = a <= b;
      2: rel = a == b;
      3: rel = a >= b;
      4: rel = a > b;
      default: rel = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] q, c1;
    logic expCmp;
    int n, gap;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    cmd = '0;
    rst_b = 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    // Reset values, unmapped read last
    for (int i = 0; i < 10; i++) begin
      rd(ra[i], q);
      check(q, re[i]);
    end
    wr(OFS_COUNT, 32'h1234);
    rd(OFS_COUNT, q);
    check(q, 32'hFFFF);
    // Free run: P+1 ticks between terminal counts, irq set and cleared
    wr(OFS_PERIOD, 32'h14);
    wr(OFS_IRQ_EN, 32'h1);
    run(32'h1);
    // This clear lands on the compare rise, so that set has to survive
    wr(OFS_CLEAR, 32'h7);
    waitTc(2000, n);
    waitTc(2000, n);
    check(n, 32'h15);
    repeat (2) @(posedge clk);
    check(irq, 1'b1);
    rd(OFS_STATUS, q);
    check(q[0], 1'b1);
    check(q[1], 1'b1);
    wr(OFS_CLEAR, 32'h1);
    rd(OFS_STATUS, q);
    check(q[0], 1'b0);
    check(irq, 1'b0);
    rd(OFS_COUNT, c1);
    rd(OFS_COUNT, q);
    check(32'(q < c1), 32'h1);
    wr(OFS_IRQ_EN, 32'h0);
    waitTc(2000, n);
    repeat (2) @(posedge clk);
    check(irq, 1'b0);
    // Divided, external edge and external level counting clocks
    wr(OFS_PERIOD, 32'h4);
    wr(OFS_DIVIDER, 32'h3);
    run(32'h101);
    waitTc(2000, n);
    waitTc(2000, n);
    check(n, 32'h14);
    cmd.extClk <= 1'b1;
    run(32'h301);
    waitTc(2000, n);
    waitTc(2000, n);
    check(n, 32'h1E);
    // Level mode ticks three clocks in six, so six ticks take twelve
    wr(OFS_PERIOD, 32'h5);
    run(32'h201);
    waitTc(2000, n);
    waitTc(2000, n);
    check(n, 32'hC);
    cmd.extClk <= 1'b0;
    // Single pass stops at zero and does not reload until restarted
    wr(OFS_PERIOD, 32'hA);
    run(32'h3);
    repeat (40) @(posedge clk);
    rd(OFS_COUNT, q);
    check(q, 32'h0);
    waitTc(50, n);
    check(n, 32'h32);
    // Gated: counts only with enable, then capture and restart
    wr(OFS_PERIOD, 32'h64);
    run(32'h5);
    repeat (3) @(posedge clk);
    rd(OFS_COUNT, q);
    check(q, 32'h64);
    cmd.enable <= 1'b1;
    repeat (5) @(posedge clk);
    cmd.enable <= 1'b0;
    repeat (4) @(posedge clk);
    rd(OFS_COUNT, q);
    check(q, 32'h5F);
    cmd.capture <= 1'b1;
    @(posedge clk);
    cmd.capture <= 1'b0;
    repeat (3) @(posedge clk);
    rd(OFS_CAPTURE, q);
    check(q, 32'h5F);
    rd(OFS_STATUS, q);
    check(q[2], 1'b1);
    cmd.restart <= 1'b1;
    repeat (2) @(posedge clk);
    cmd.restart <= 1'b0;
    repeat (2) @(posedge clk);
    rd(OFS_COUNT, q);
    check(q, 32'h64);
    // Every relation, and one spare code, against a held count of 100
    for (int m = 0; m < 6; m++) begin
      for (int k = 0; k < 2; k++) begin
        wr(OFS_COMPARE, k ? 32'h63 : 32'h64);
        wr(OFS_CTRL, 32'h5 | (m << 3));
        repeat (6) @(posedge clk);
        expCmp = rel(m, 16'h0064, k ? 16'h0063 : 16'h0064);
        check(fabOut.cmp, expCmp);
      end
    end
    // Kill overrides a true compare
    wr(OFS_COMPARE, 32'h64);
    wr(OFS_CTRL, 32'hD);
    repeat (6) @(posedge clk);
    cmd.kill <= 1'b1;
    repeat (3) @(posedge clk);
    check(fabOut.cmp, 1'b0);
    cmd.kill <= 1'b0;
    repeat (6) @(posedge clk);
    check(fabOut.cmp, 1'b1);
    // Complementary drives with a gap of deadband plus one tick
    wr(OFS_DEADBAND, 32'h3);
    wr(OFS_CTRL, 32'h4D);
    repeat (8) @(posedge clk);
    check(fabOut.tc, 1'b0);
    wr(OFS_COMPARE, 32'h63);
    gap = 0;
    for (int i = 0; i < 50 && fabOut.tc !== 1'b1; i++) begin
      @(posedge clk);
      if (fabOut === 2'b00) gap++;
    end
    check(gap, 32'h4);
    cmd.kill <= 1'b1;
    repeat (3) @(posedge clk);
    check(fabOut.tc, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire
